// >>> common/tre_pkg.sv
// tre_pkg: constants and types shared by the transfer record entry block.
// assumes a 64-bit machine register width and a depth of up to 256 entries.
package tre_pkg;
   localparam int MACHINE_REG_WIDTH_W         = 64;
   localparam int ENTRY_IDX_W     = 8;
   // indirect select window for the entries
   localparam logic [11:0] SEL_LO = 12'h200;
   localparam logic [11:0] SEL_HI = 12'h2FF;
   // csr addresses of the supervisor recording state (choices, see note)
   localparam logic [11:0] CSR_CTL    = 12'h14E;
   localparam logic [11:0] CSR_VSCTL  = 12'h24E;
   localparam logic [11:0] CSR_DEPTH  = 12'h15F;
   localparam logic [11:0] CSR_STATUS = 12'h14F;
   localparam logic [11:0] CSR_SISEL  = 12'h150;
   localparam logic [11:0] CSR_VSSEL  = 12'h250;
   // indirect data register numbers 1..6
   localparam logic [2:0] IREG_SRC  = 3'h1;
   localparam logic [2:0] IREG_TGT  = 3'h2;
   localparam logic [2:0] IREG_META = 3'h3;
   // clear instruction encoding
   localparam logic [31:0] CLEAR_INSTR = 32'h10400073;
   // metadata, target flag and state-enable bit positions
   localparam int META_TYPE_LSB  = 0;
   localparam int META_CCV_BIT   = 15;
   localparam int META_CC_LSB    = 16;
   localparam int TGT_FLAG_BIT   = 0;
   localparam int STATEEN_IND_BIT = 60;
   // reset values
   localparam logic [63:0] ENTRY_RST = 64'h0000000000000000;
   // privilege levels
   localparam logic [1:0] PRIV_U = 2'h0;
   localparam logic [1:0] PRIV_S = 2'h1;
   localparam logic [1:0] PRIV_M = 2'h3;
   typedef enum logic [1:0] {TRE_NONE, TRE_ILLEGAL, TRE_VIRTUAL} tre_exc_e;
endpackage

// >>> common/tre_mem_if.sv
// tre_mem_if: port bundle between the entry logic and its storage.
// assumes one write and one read port, both on the core clock.
`timescale 1ns/100ps
interface tre_mem_if #(parameter int AW = 8, parameter int DW = 144);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> design/tre_entry_mem.sv
// tre_entry_mem: physical entry storage with registered read data.
// assumes the controller keeps a separate valid bit per entry for clearing.
`timescale 1ns/100ps
module tre_entry_mem #(
   parameter int AW = 8,
   parameter int DW = 144
) (
   input  wire logic  clk,
   tre_mem_if.mem     m
);
   logic [DW-1:0] store [0:(1<<AW)-1];
   // synchronous write and registered read
   always_ff @(posedge clk) begin
      if (m.we) begin
         store[m.waddr] <= m.wdata;
      end
      m.rdata <= store[m.raddr];
   end
endmodule

// >>> design/tre_entry_access.sv
// tre_entry_access: entry registers, clear instruction and state-enable checks.
// assumes the core presents retirement records, csr accesses and instructions
// as single-cycle strobes, and consumes exceptions one cycle later.
//
// Function
// - target record keeps full destination pc, any write accepted.
// - mispredict flag set by hardware when implemented, else reads zero.
// - target layout is pc 63:1 above, mispredict flag in bit 0.
// - narrow-width writes, software or hardware, are zero-extended.
// - metadata record is 64 bits; absent fields read zero.
// - four-bit transfer type in metadata bits 3:0.
// - cycle-count valid flag accepts any write, reads legal.
// - cycle count is 4-bit exponent over 12-bit mantissa.
// - undefined metadata bits read zero.
// - clear instruction 0x104 zeroes every entry register.
// - clear also zeroes cycle counter and valid indication.
// - after clear, entry reads return zero until next transfer or software write to it.
// - first transfer after clear records cleared count-valid flag.
// - clear traps illegal in user, virtual in virtual user.
// - machine enable clear blocks lower modes with illegal exception.
// - recording still updates entries when machine enable is clear.
// - hypervisor enable gates guest access, reads zero if machine clear.
// - guest supervisor blocked by hypervisor enable gets virtual exception.
// - recording still updates entries while virtualized and gated.
// - guest access to depth register raises virtual exception, illegal if machine enable is clear.
// - state-enable bit 60 restricts indirect select and data access.
// - selects 0x200..0x2FF map entries; registers four to six read zero.
// - guest indirect path reaches the same physical entries.
`timescale 1ns/100ps
module tre_entry_access #(
   parameter int  DEPTH_W   = 8,
   parameter bit  HAS_WRONG_PREDICTION_FLAG  = 1'b1,
   parameter bit  HAS_TYPE  = 1'b1,
   parameter bit  HAS_CC    = 1'b1,
   parameter bit  HAS_HYP   = 1'b1
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // recording port from retirement
   input  wire logic                 rec_valid,
   input  wire logic [63:0]          rec_source,
   input  wire logic [63:0]          rec_target,
   input  wire logic                 rec_wrong_prediction_flag,
   input  wire logic [3:0]           rec_type,
   input  wire logic [15:0]          rec_cycle_count,
   input  wire logic                 rec_narrow,
   input  wire logic [DEPTH_W-1:0]   wr_ptr,
   input  wire logic [DEPTH_W:0]     depth,
   // current privilege context
   input  wire logic [1:0]           priv,
   input  wire logic                 virt,
   input  wire logic                 machine_state_enable_bit,
   input  wire logic                 hyp_state_enable_wr,
   input  wire logic                 mstateen_ind,
   input  wire logic                 hstateen_ind,
   // csr access strobe
   input  wire logic                 csr_valid,
   input  wire logic                 csr_write,
   input  wire logic [11:0]          csr_addr,
   input  wire logic [2:0]           csr_ireg,
   input  wire logic [11:0]          csr_select,
   input  wire logic [63:0]          csr_wdata,
   // instruction strobe
   input  wire logic                 instr_valid,
   input  wire logic [31:0]          instr,
   // answers
   output logic                      csr_rvalid,
   output logic [63:0]               csr_rdata,
   output logic                      exc_illegal,
   output logic                      exc_virtual,
   output logic                      hyp_state_enable_bit,
   output logic                      count_clear
);
   localparam int DW = 64;
   localparam int NENT = 1 << DEPTH_W;

   // one bank per entry register, so a software write into a valid entry changes only its own word
   tre_mem_if #(.AW(DEPTH_W), .DW(DW)) mif_src ();
   tre_mem_if #(.AW(DEPTH_W), .DW(DW)) mif_tgt ();
   tre_mem_if #(.AW(DEPTH_W), .DW(DW)) mif_meta ();

   tre_entry_mem #(.AW(DEPTH_W), .DW(DW)) u_mem_src (
      .clk (clk),
      .m   (mif_src)
   );
   tre_entry_mem #(.AW(DEPTH_W), .DW(DW)) u_mem_tgt (
      .clk (clk),
      .m   (mif_tgt)
   );
   tre_entry_mem #(.AW(DEPTH_W), .DW(DW)) u_mem_meta (
      .clk (clk),
      .m   (mif_meta)
   );

   logic [NENT-1:0]    entry_valid;
   logic [NENT-1:0]    next_entry_valid;
   wire                hyp_en = HAS_HYP && hyp_state_enable_wr; // raw bit gates guests at once
   logic               first_after_clear;
   logic               rd_pend;
   logic               rd_zero;
   logic [2:0]         rd_ireg;
   logic               rd_live;
   tre_pkg::tre_exc_e  exc;

   // zero-extend a value when the current register width is narrow
   function automatic logic [63:0] widen(input logic [63:0] v, input logic narrow);
      widen = narrow ? {32'h00000000, v[31:0]} : v;
   endfunction

   // physical slot of a logical entry
   function automatic logic [DEPTH_W-1:0] phys(input logic [DEPTH_W-1:0] ptr,
                                               input logic [DEPTH_W-1:0] logical,
                                               input logic [DEPTH_W:0]   dep);
      logic [DEPTH_W:0] raw;
      raw  = {1'b0, ptr} - {1'b0, logical} - {{DEPTH_W{1'b0}}, 1'b1};
      phys = DEPTH_W'(raw & (dep - {{DEPTH_W{1'b0}}, 1'b1}));
   endfunction

   // legalise target and metadata values
   function automatic logic [63:0] tgt_legal(input logic [63:0] v);
      tgt_legal = {v[63:1], HAS_WRONG_PREDICTION_FLAG ? v[tre_pkg::TGT_FLAG_BIT] : 1'b0};
   endfunction

   function automatic logic [63:0] meta_legal(input logic [63:0] v);
      logic [63:0] r;
      r = 64'h0000000000000000;
      if (HAS_TYPE) r[3:0] = v[3:0];
      if (HAS_CC) begin
         r[tre_pkg::META_CCV_BIT] = v[tre_pkg::META_CCV_BIT];
         r[31:16] = v[31:16];
      end
      meta_legal = r;
   endfunction

   // instruction and csr decode
   wire        is_clear   = instr_valid && (instr == tre_pkg::CLEAR_INSTR);
   wire        below_m    = (priv != tre_pkg::PRIV_M);
   wire        sel_in_win = (csr_select >= tre_pkg::SEL_LO) && (csr_select <= tre_pkg::SEL_HI);
   wire        is_ind     = csr_valid && (csr_ireg != 3'h0);
   wire        is_entry   = is_ind && sel_in_win;
   wire        is_selreg  = csr_valid && ((csr_addr == tre_pkg::CSR_SISEL) ||
                                          (csr_addr == tre_pkg::CSR_VSSEL));
   wire        is_depth   = csr_valid && (csr_addr == tre_pkg::CSR_DEPTH);
   wire        is_ctlstat = csr_valid && ((csr_addr == tre_pkg::CSR_CTL) ||
                                          (csr_addr == tre_pkg::CSR_VSCTL) ||
                                          (csr_addr == tre_pkg::CSR_STATUS));
   wire        is_sstate  = is_ctlstat || is_entry || is_depth;
   wire        guest_s    = virt && (priv == tre_pkg::PRIV_S);
   wire        guest_u    = virt && (priv == tre_pkg::PRIV_U);
   wire        user_nv    = !virt && (priv == tre_pkg::PRIV_U);
   wire        ind_any    = is_ind || is_selreg;
   wire        m_block    = below_m && !machine_state_enable_bit &&
                            (is_sstate || is_clear);
   wire        ind_mblock = below_m && !mstateen_ind && ind_any;
   wire        ind_hblock = virt && !hstateen_ind && ind_any;
   wire        h_block    = HAS_HYP && guest_s && !hyp_en &&
                            ((is_ctlstat || is_entry) || is_clear);
   wire        depth_vs   = virt && is_depth;
   wire        clr_user   = is_clear && user_nv;
   wire        clr_vuser  = is_clear && guest_u;
   wire        ent_lo_rd  = is_entry && (csr_ireg <= tre_pkg::IREG_META);

   // exception priority: machine restriction first, then virtual ones
   always_comb begin
      exc = tre_pkg::TRE_NONE;
      if (m_block || ind_mblock || clr_user) begin
         exc = tre_pkg::TRE_ILLEGAL;
      end else if (ind_hblock || h_block || depth_vs || clr_vuser) begin
         exc = tre_pkg::TRE_VIRTUAL;
      end
   end

   wire        allowed    = (exc == tre_pkg::TRE_NONE);
   wire        do_clear   = is_clear && allowed;
   wire        sw_write   = ent_lo_rd && csr_write && allowed;
   wire [DEPTH_W-1:0] sw_log  = csr_select[DEPTH_W-1:0];
   wire        sw_in_dep  = ({1'b0, sw_log} < depth);
   wire [DEPTH_W-1:0] sw_slot = phys(wr_ptr, sw_log, depth);

   // hardware record image; software write into a valid entry only changes one word
   wire [63:0] hw_tgt  = widen(tgt_legal({rec_target[63:1], rec_wrong_prediction_flag}), rec_narrow);
   wire [63:0] hw_meta_raw = {32'h00000000, rec_cycle_count, !first_after_clear,
                              11'h000, rec_type};
   wire [63:0] hw_meta = meta_legal(hw_meta_raw);
   wire [63:0] sw_val  = widen(csr_wdata, rec_narrow);

   // storage ports: recording wins over software; software into a cleared entry zeroes the rest
   wire               sw_we    = sw_write && sw_in_dep;
   wire               sw_fresh = !entry_valid[sw_slot];
   wire               sw_src   = (csr_ireg == tre_pkg::IREG_SRC);
   wire               sw_tgt   = (csr_ireg == tre_pkg::IREG_TGT);
   wire               sw_meta  = (csr_ireg == tre_pkg::IREG_META);
   wire [DEPTH_W-1:0] mem_wa   = rec_valid ? wr_ptr : sw_slot;
   assign mif_src.we     = rec_valid || (sw_we && (sw_src || sw_fresh));
   assign mif_tgt.we     = rec_valid || (sw_we && (sw_tgt || sw_fresh));
   assign mif_meta.we    = rec_valid || (sw_we && (sw_meta || sw_fresh));
   assign mif_src.waddr  = mem_wa;
   assign mif_tgt.waddr  = mem_wa;
   assign mif_meta.waddr = mem_wa;
   assign mif_src.wdata  = rec_valid ? widen(rec_source, rec_narrow) :
                           sw_src ? sw_val : 64'h0000000000000000;
   assign mif_tgt.wdata  = rec_valid ? hw_tgt :
                           sw_tgt ? tgt_legal(sw_val) : 64'h0000000000000000;
   assign mif_meta.wdata = rec_valid ? hw_meta :
                           sw_meta ? meta_legal(sw_val) : 64'h0000000000000000;
   assign mif_src.raddr  = sw_slot;
   assign mif_tgt.raddr  = sw_slot;
   assign mif_meta.raddr = sw_slot;

   // valid bits make cleared entries read zero without touching storage
   always_comb begin
      next_entry_valid = entry_valid;
      if (do_clear) begin
         next_entry_valid = '0;
      end
      if (rec_valid) begin
         next_entry_valid[wr_ptr] = 1'b1;
      end else if (sw_write && sw_in_dep) begin
         next_entry_valid[sw_slot] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_valid <= '0;
      end else begin
         entry_valid <= next_entry_valid;
      end
   end

   // first-record marker and cycle counter clear pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_after_clear <= 1'b1;
         count_clear       <= 1'b0;
      end else begin
         count_clear <= do_clear;
         if (do_clear) begin
            first_after_clear <= 1'b1;
         end else if (rec_valid) begin
            first_after_clear <= 1'b0;
         end
      end
   end

   // hypervisor enable reads zero while the machine bit is clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hyp_state_enable_bit <= 1'b0;
      end else begin
         hyp_state_enable_bit <= HAS_HYP && hyp_state_enable_wr &&
                                 machine_state_enable_bit;
      end
   end

   // read pipeline: capture, then select from registered storage data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend <= 1'b0;
         rd_zero <= 1'b0;
         rd_ireg <= 3'h0;
         rd_live <= 1'b0;
      end else begin
         rd_pend <= is_entry && !csr_write && allowed;
         rd_zero <= !sw_in_dep || !ent_lo_rd;
         rd_ireg <= csr_ireg;
         rd_live <= entry_valid[sw_slot] && !do_clear;
      end
   end

   wire [63:0] rd_word = (rd_ireg == tre_pkg::IREG_SRC) ? mif_src.rdata :
                         (rd_ireg == tre_pkg::IREG_TGT) ? mif_tgt.rdata :
                                                          mif_meta.rdata;
   wire [63:0] rd_out  = (rd_zero || !rd_live) ? 64'h0000000000000000 : rd_word;

   // registered answers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csr_rvalid  <= 1'b0;
         csr_rdata   <= tre_pkg::ENTRY_RST;
         exc_illegal <= 1'b0;
         exc_virtual <= 1'b0;
      end else begin
         csr_rvalid  <= rd_pend;
         csr_rdata   <= rd_pend ? rd_out : 64'h0000000000000000;
         exc_illegal <= (exc == tre_pkg::TRE_ILLEGAL);
         exc_virtual <= (exc == tre_pkg::TRE_VIRTUAL);
      end
   end
endmodule

// >>> testbench/tre_entry_access_assertions.sv
// tre_entry_access_assertions: port-level timing checks of the entry access block.
// assumes it is bound to tre_entry_access and shares its clock and reset.
`timescale 1ns/100ps
module tre_entry_access_assertions (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [1:0]  priv,
   input wire logic        virt,
   input wire logic        machine_state_enable_bit,
   input wire logic        hyp_state_enable_wr,
   input wire logic        csr_valid,
   input wire logic        csr_write,
   input wire logic [11:0] csr_addr,
   input wire logic [2:0]  csr_ireg,
   input wire logic        instr_valid,
   input wire logic [31:0] instr,
   input wire logic        csr_rvalid,
   input wire logic [63:0] csr_rdata,
   input wire logic        exc_illegal,
   input wire logic        exc_virtual,
   input wire logic        hyp_state_enable_bit,
   input wire logic        count_clear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // request decode shared by the checks
   wire is_clr = instr_valid && instr == tre_pkg::CLEAR_INSTR;
   wire is_dep = csr_valid && csr_ireg == 3'h0 && csr_addr == tre_pkg::CSR_DEPTH;
   wire mse    = machine_state_enable_bit;
   AST_CLR_M: assert property (is_clr && priv == tre_pkg::PRIV_M |=>
      count_clear && !exc_illegal && !exc_virtual) else $error("clear from machine mode failed");
   AST_CLR_USER: assert property (is_clr && priv == tre_pkg::PRIV_U && !virt && mse |=>
      exc_illegal && !count_clear) else $error("clear in user mode did not trap");
   AST_CLR_VU: assert property (is_clr && priv == tre_pkg::PRIV_U && virt && mse
      && hyp_state_enable_wr |=> exc_virtual && !exc_illegal) else $error("virtual user clear");
   AST_MSE_OFF: assert property ((is_clr || is_dep) && priv != tre_pkg::PRIV_M && !mse
      |=> exc_illegal) else $error("machine enable clear did not trap");
   AST_HSE_OFF: assert property (is_clr && priv == tre_pkg::PRIV_S && virt && mse
      && !hyp_state_enable_wr |=> exc_virtual) else $error("guest clear not trapped");
   AST_DEPTH_VS: assert property (is_dep && priv == tre_pkg::PRIV_S && virt && mse
      |=> exc_virtual) else $error("guest depth access not trapped");
   AST_HYP_RB: assert property (!mse |=> !hyp_state_enable_bit)
      else $error("hypervisor enable readback not zero");
   AST_M_FREE: assert property (csr_valid && priv == tre_pkg::PRIV_M |=>
      !exc_illegal && !exc_virtual) else $error("machine access trapped");
   AST_RD_PIPE: assert property (csr_rvalid |-> $past(csr_valid, 2) && !$past(csr_write, 2))
      else $error("read data without a read two cycles before");
   AST_RD_IDLE: assert property (!csr_rvalid |-> csr_rdata == 64'h0)
      else $error("read data not zero while idle");
   AST_EXC_NO_RD: assert property (exc_illegal || exc_virtual |=> !csr_rvalid)
      else $error("blocked access returned data");
   // main scenarios reached
   COV_CLEAR: cover property (count_clear);
   COV_VIRT: cover property (exc_virtual);
   COV_DATA: cover property (csr_rvalid && csr_rdata != 64'h0);
endmodule
bind tre_entry_access tre_entry_access_assertions tre_entry_access_assertions_i (
   .clk(clk), .rst_n(rst_n), .priv(priv), .virt(virt),
   .machine_state_enable_bit(machine_state_enable_bit),
   .hyp_state_enable_wr(hyp_state_enable_wr), .csr_valid(csr_valid),
   .csr_write(csr_write), .csr_addr(csr_addr), .csr_ireg(csr_ireg),
   .instr_valid(instr_valid), .instr(instr), .csr_rvalid(csr_rvalid),
   .csr_rdata(csr_rdata), .exc_illegal(exc_illegal), .exc_virtual(exc_virtual),
   .hyp_state_enable_bit(hyp_state_enable_bit), .count_clear(count_clear));

// >>> testbench/tre_core_model.sv
// tre_core_model: retirement side of the core, presents qualified transfers.
// assumes a buffer depth of sixteen; owns the status write pointer.
`timescale 1ns/100ps
module tre_core_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   output logic             rec_valid,
   output logic [63:0]      rec_source,
   output logic [63:0]      rec_target,
   output logic             rec_wrong_prediction_flag,
   output logic [3:0]       rec_type,
   output logic [15:0]      rec_cycle_count,
   output logic             rec_narrow,
   output logic [7:0]       wr_ptr
);
   initial begin
      rec_valid = 1'b0;
      {rec_source, rec_target, rec_wrong_prediction_flag, rec_type, rec_cycle_count, rec_narrow} = '0;
   end
   // write pointer advances on each recorded transfer, wraps at depth-1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wr_ptr <= 8'h00;
      else if (rec_valid)
         wr_ptr <= (wr_ptr + 8'h01) & 8'h0F;
   end
   // one retirement whatever the mode or enables: recording is never gated
   task automatic retire(input logic [63:0] tgt, input logic wrong_prediction_flag, input logic [3:0] typ,
                         input logic [15:0] cc, input logic narrow);
      @(negedge clk);
      rec_valid = 1'b1;
      rec_target = tgt;
      rec_source = ~tgt;
      rec_wrong_prediction_flag = wrong_prediction_flag;
      rec_type = typ;
      rec_cycle_count = cc;
      rec_narrow = narrow;
      @(negedge clk);
      rec_valid = 1'b0;
      rec_target = ~tgt; // fields no longer valid, so target and cycle count show inverted values
      rec_cycle_count = ~cc;
   endtask
endmodule

// >>> testbench/tre_entry_access_tb.sv
// tre_entry_access_tb: self-checking bench of the entry access block.
// assumes the core model drives retirements and the bench plays csr and decode.
`timescale 1ns/100ps
module tre_entry_access_tb;
   logic        clk = 1'b0, rst_n = 1'b0, virt = 1'b0, csr_valid = 1'b0, csr_write = 1'b0;
   logic [1:0]  priv = tre_pkg::PRIV_M;
   logic        machine_state_enable_bit = 1'b1, hyp_state_enable_wr = 1'b1;
   logic        mstateen_ind = 1'b1, hstateen_ind = 1'b1, instr_valid = 1'b0;
   logic [11:0] csr_addr = 12'h000, csr_select = 12'h000;
   logic [2:0]  csr_ireg = 3'h0;
   logic [63:0] csr_wdata = 64'h0, csr_rdata, rd_val, rec_source, rec_target;
   logic [31:0] instr = 32'h0;
   logic        csr_rvalid, exc_illegal, exc_virtual, hyp_state_enable_bit, count_clear;
   logic        rec_valid, rec_wrong_prediction_flag, rec_narrow, clr_seen;
   logic [3:0]  rec_type;
   logic [15:0] rec_cycle_count;
   logic [7:0]  wr_ptr;
   logic [1:0]  exc_seen;
   int          fails = 0, num_checks = 0;
   always #4 clk = ~clk;
   tre_core_model tre_core_model_i (.clk(clk), .rst_n(rst_n), .rec_valid(rec_valid),
      .rec_source(rec_source), .rec_target(rec_target), .rec_wrong_prediction_flag(rec_wrong_prediction_flag),
      .rec_type(rec_type), .rec_cycle_count(rec_cycle_count), .rec_narrow(rec_narrow),
      .wr_ptr(wr_ptr));
   tre_entry_access tre_entry_access_i (.clk(clk), .rst_n(rst_n), .rec_valid(rec_valid),
      .rec_source(rec_source), .rec_target(rec_target), .rec_wrong_prediction_flag(rec_wrong_prediction_flag),
      .rec_type(rec_type), .rec_cycle_count(rec_cycle_count), .rec_narrow(rec_narrow),
      .wr_ptr(wr_ptr), .depth(9'h010), .priv(priv), .virt(virt),
      .machine_state_enable_bit(machine_state_enable_bit),
      .hyp_state_enable_wr(hyp_state_enable_wr), .mstateen_ind(mstateen_ind),
      .hstateen_ind(hstateen_ind), .csr_valid(csr_valid), .csr_write(csr_write),
      .csr_addr(csr_addr), .csr_ireg(csr_ireg), .csr_select(csr_select),
      .csr_wdata(csr_wdata), .instr_valid(instr_valid), .instr(instr),
      .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata), .exc_illegal(exc_illegal),
      .exc_virtual(exc_virtual), .hyp_state_enable_bit(hyp_state_enable_bit),
      .count_clear(count_clear));
   // compare and report one value
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one request: 0 clear, 1 depth csr, 2 indirect data, 3 select csr
   task automatic op(input logic [1:0] kind, input logic [2:0] ireg, input logic [11:0] sel,
                     input logic wr, input logic [63:0] wd);
      @(negedge clk);
      instr_valid = (kind == 2'h0);
      instr = tre_pkg::CLEAR_INSTR;
      csr_valid = (kind != 2'h0);
      csr_write = wr;
      csr_ireg = (kind == 2'h2) ? ireg : 3'h0;
      csr_select = sel;
      csr_wdata = wd;
      csr_addr = kind == 2'h1 ? tre_pkg::CSR_DEPTH : kind == 2'h3 ? tre_pkg::CSR_SISEL : 12'h151;
      @(negedge clk);
      {instr_valid, csr_valid, csr_write, instr} = '0;
      csr_wdata = ~wd;
      csr_select = ~sel;
      exc_seen = {exc_virtual, exc_illegal};
      clr_seen = count_clear;
      @(negedge clk);
      rd_val = (csr_rvalid === 1'b1) ? csr_rdata : 64'hBAD0BAD0BAD0BAD0;
   endtask
   task automatic rd(input string nm, input logic [2:0] ireg, input logic [11:0] idx,
                     input logic [63:0] e);
      op(2'h2, ireg, tre_pkg::SEL_LO + idx, 1'b0, 64'h0);
      chk(nm, e, rd_val);
   endtask
   // clear from machine mode empties the entries
   task automatic t_clear;
      op(2'h0, 3'h0, 12'h0, 1'b0, 64'h0);
      chk("count_clear", 64'h1, {63'h0, clr_seen});
      chk("clear exception", 64'h0, {62'h0, exc_seen});
      rd("target after clear", 3'h2, 12'h000, 64'h0);
      rd("metadata after clear", 3'h3, 12'h000, 64'h0);
   endtask
   // records made by a gated guest, read back from machine mode
   task automatic t_record;
      {priv, virt, machine_state_enable_bit, hyp_state_enable_wr} = {tre_pkg::PRIV_S, 3'b100};
      tre_core_model_i.retire(64'h123456789ABCDEF0, 1'b1, 4'h5, 16'hA5C3, 1'b0);
      tre_core_model_i.retire(64'h8000000000000100, 1'b0, 4'hA, 16'h0FFF, 1'b0);
      {priv, virt, machine_state_enable_bit, hyp_state_enable_wr} = {tre_pkg::PRIV_M, 3'b011};
      rd("target newest", 3'h2, 12'h000, 64'h8000000000000100);
      rd("metadata newest", 3'h3, 12'h000, 64'h000000000FFF800A);
      rd("target older", 3'h2, 12'h001, 64'h123456789ABCDEF1);
      rd("metadata older", 3'h3, 12'h001, 64'h00000000A5C30005);
      op(2'h2, 3'h3, tre_pkg::SEL_LO + 12'h001, 1'b0, 64'h0);
      chk("first count valid", 64'h0, {63'h0, rd_val[15]});
      rd("unused data register", 3'h4, 12'h000, 64'h0);
      rd("beyond depth", 3'h2, 12'h010, 64'h0);
   endtask
   // narrow width: hardware and software writes are zero-extended
   task automatic t_narrow;
      tre_core_model_i.retire(64'hFFFFFFFF80000007, 1'b1, 4'h1, 16'h0, 1'b1);
      rd("narrow record", 3'h2, 12'h000, 64'h0000000080000007);
      op(2'h2, 3'h2, tre_pkg::SEL_LO, 1'b1, 64'hFFFFFFFF12345678);
      rd("narrow write", 3'h2, 12'h000, 64'h0000000012345678);
      rd("metadata kept", 3'h3, 12'h000, 64'h0000000000008001);
   endtask
   // state-enable gating, row: priv virt mse hse ind kind expected
   task automatic t_traps;
      logic [9:0] rows [0:10] = '{10'b00_0111_00_01, 10'b00_1111_00_10, 10'b01_0011_00_01,
         10'b01_0011_01_01, 10'b01_0011_10_01, 10'b01_1101_00_10, 10'b01_1111_01_10,
         10'b11_0001_00_00, 10'b01_0111_10_00, 10'b01_0110_11_01, 10'b11_0000_10_00};
      chk("hyp enable set", 64'h1, {63'h0, hyp_state_enable_bit});
      machine_state_enable_bit = 1'b0;
      hyp_state_enable_wr = 1'b1;
      repeat (2) @(negedge clk);
      chk("hyp enable readback", 64'h0, {63'h0, hyp_state_enable_bit});
      for (int i = 0; i < 11; i++) begin
         {priv, virt, machine_state_enable_bit, hyp_state_enable_wr} = rows[i][9:5];
         {mstateen_ind, hstateen_ind} = {2{rows[i][4]}};
         op(rows[i][3:2], 3'h2, tre_pkg::SEL_LO, 1'b0, 64'h0);
         chk("exception", {62'h0, rows[i][1:0]}, {62'h0, exc_seen});
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_clear();
      t_record();
      t_narrow();
      t_traps();
      wrap_up();
   end
   // hang guard, far beyond the hundred or so cycles the tests need
   initial begin
      #(8 * 3000);
      fails++;
      wrap_up();
   end
endmodule
